// File: pkg/link_test_consts.vh
// constants for the serial link test and checksum control block
// assumes a 32-bit apb slave on a 200 MHz pclk, byte address = 4 x index
//
// Operation
// R1: mode 00 sums whole configuration octets
// R2: mode 01 sums individual configuration fields
// R3: mode 10 forces checksum to zero
// R4: insertion point selects sample, encoder, scrambler
// R5: pattern 0000 passes normal converter data
// R6: 0001 checkerboard, 0010 ones/zeros word toggle
// R7: 0100 pn23, 0110 pn9, 0111 pn7, 1000 ramp
// R8: 1110 repeats user pattern continuously
// R9: 1111 sends user pattern once
// R10: link test 000 means normal link
// R11: link test 001 sends /D21.5/ continuously
// R12: link test 100 sends modified jitter sequence
// R13: link test 101 and 110 scrambled sequences
// R14: unlisted codes behave as normal operation
`ifndef LINK_TEST_CONSTS_VH
`define LINK_TEST_CONSTS_VH

// ***********************************
// register indices (byte address = index * 4)
// ***********************************
`define IDX_MODE_CTL2 16'h0572
`define IDX_MODE_CTL3 16'h0573
`define IDX_MODE_CTL4 16'h0574
`define IDX_MF_OFFSET 16'h0578
`define IDX_DEV_ID 16'h0580
`define IDX_USER_LO 16'h0590
`define IDX_USER_HI 16'h0591
`define IDX_STATUS 16'h0592
`define RST_REG8 8'h00

// ***********************************
// field positions
// ***********************************
`define CHK_MSB 7
`define CHK_LSB 6
`define INS_MSB 5
`define INS_LSB 4
`define PAT_MSB 3
`define PAT_LSB 0
`define LLT_MSB 2
`define LLT_LSB 0

// ***********************************
// codes
// ***********************************
`define CHK_OCTETS 2'h0
`define CHK_FIELDS 2'h1
`define CHK_ZERO 2'h2
`define PAT_NORMAL 4'h0
`define PAT_CHECKER 4'h1
`define PAT_TOGGLE 4'h2
`define PAT_PN23 4'h4
`define PAT_PN9 4'h6
`define PAT_PN7 4'h7
`define PAT_RAMP 4'h8
`define PAT_USER_REP 4'hE
`define PAT_USER_ONE 4'hF
`define LLT_NORMAL 3'h0
`define LLT_D215 3'h1
`define LLT_RPAT 3'h4
`define LLT_JSPAT 3'h5
`define LLT_JTSPAT 3'h6
`define CHAR_D215 8'hB5
`define CHECKER_A 16'hAAAA
`define CHECKER_B 16'h5555
`define WORD_ONES 16'hFFFF
`define WORD_ZERO 16'h0000

// ***********************************
// structure
// ***********************************
`define SAMPLE_W 16
`define FIFO_DEPTH 16
`define FIFO_AW 4
`define CFG_OCTETS 11

`endif

// File: design/sample_fifo.v
// synchronous fifo for sample words with valid/ready on both sides
// assumes a single clock and an asynchronous active-low reset
`timescale 1ns/1ps
module sample_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire pclk,
   input wire presetn,
   input wire [WIDTH-1:0] in_data,
   input wire in_valid,
   output wire in_ready,
   output reg [WIDTH-1:0] out_data,
   output reg out_valid,
   input wire out_ready,
   output wire full,
   output wire empty
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wr_ptr;
   reg [AW:0] rd_ptr;
   wire [AW:0] count;
   wire do_wr;
   wire do_rd;

   // ***********************************
   // flags
   // ***********************************
   assign count = wr_ptr - rd_ptr;
   assign full = (count == DEPTH[AW:0]);
   assign empty = (count == {(AW+1){1'b0}});
   assign in_ready = ~full;
   assign do_wr = in_valid & ~full;
   // refill the output register whenever it is free or being taken
   assign do_rd = ~empty & (~out_valid | out_ready);

   // storage has no reset, only pointers and the registered read port do
   always @(posedge pclk) begin
      if (do_wr) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   // pointers and registered read port
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr <= {(AW+1){1'b0}};
         rd_ptr <= {(AW+1){1'b0}};
         out_data <= {WIDTH{1'b0}};
         out_valid <= 1'b0;
      end else begin
         if (do_wr) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (do_rd) begin
            out_data <= mem[rd_ptr[AW-1:0]];
            out_valid <= 1'b1;
            rd_ptr <= rd_ptr + 1'b1;
         end else if (out_ready) begin
            out_valid <= 1'b0;
         end
      end
   end
endmodule

// File: design/pn_source.v
// free-standing fibonacci lfsr giving one 16-bit word per advance
// assumes the caller pulses advance once per consumed word
`timescale 1ns/1ps
module pn_source #(
   parameter LEN = 7,
   parameter TAP = 6
) (
   input wire pclk,
   input wire presetn,
   input wire advance,
   output reg [15:0] word
);
   reg [LEN-1:0] state;
   reg [LEN-1:0] next_state;
   reg [15:0] next_word;
   integer i;

   // sixteen serial steps folded into one clock, msb first
   always @* begin
      next_state = state;
      next_word = 16'h0000;
      for (i = 15; i >= 0; i = i - 1) begin
         next_word[i] = next_state[LEN-1];
         next_state = {next_state[LEN-2:0], next_state[LEN-1] ^ next_state[TAP-1]};
      end
   end

   // all-ones seed: the all-zero state would lock up
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= {LEN{1'b1}};
         word <= 16'h0000;
      end else if (advance) begin
         state <= next_state;
         word <= next_word;
      end
   end
endmodule

// File: design/link_test_ctl.v
// test pattern, insertion point and configuration checksum control for
// the transmit side of a serial converter link, with an apb register port
// assumes samples arrive synchronous to pclk; the framer downstream honours
// insert_point and link_test_mode and applies the encoding itself
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "link_test_consts.vh"
module link_test_ctl (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [15:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [15:0] in_data,
   input wire in_valid,
   output wire in_ready,
   output reg [15:0] out_data,
   output reg out_valid,
   input wire out_ready,
   input wire [87:0] cfg_octets,
   output reg [7:0] config_checksum,
   output reg [1:0] insert_point,
   output reg test_active,
   output reg [2:0] link_test_mode,
   output reg [7:0] link_char,
   output reg [7:0] link_mode_second,
   output reg [7:0] multiframe_phase_offset,
   output reg [7:0] device_identifier
);
   // ***********************************
   // register file
   // ***********************************
   reg [7:0] link_mode_control_third;
   reg [7:0] link_mode_control_fourth;
   reg [7:0] user_lo;
   reg [7:0] user_hi;
   reg single_done;
   reg [15:0] ramp;
   reg phase;
   reg [7:0] link_seq;
   wire [15:0] idx;
   wire setup;
   wire wr_take;
   wire rd_take;
   wire mapped;
   wire [1:0] chk_mode;
   wire [3:0] pat_code;
   wire pat_known;
   wire llt_known;
   wire load;
   wire fifo_valid;
   wire fifo_full;
   wire fifo_empty;
   wire fifo_take;
   wire [15:0] fifo_data;
   wire [15:0] pn23_word;
   wire [15:0] pn9_word;
   wire [15:0] pn7_word;
   wire adv23;
   wire adv9;
   wire adv7;
   wire user_sent;
   wire clr_done;
   reg [7:0] next_checksum;
   reg [7:0] sum_oct;
   reg [7:0] sum_fld;
   reg [15:0] next_out;
   reg use_pattern;
   reg [7:0] next_rdata;
   reg [7:0] next_char;
   integer k;

   // the word address is the printed index; the low two bits must be zero
   assign idx = {2'b00, paddr[15:2]};
   assign setup = psel & penable & ~pready;
   assign wr_take = setup & pwrite & mapped;
   assign rd_take = setup & ~pwrite & mapped;
   assign mapped = (paddr[1:0] == 2'b00) &&
      (idx == `IDX_MODE_CTL2 || idx == `IDX_MODE_CTL3 || idx == `IDX_MODE_CTL4 ||
       idx == `IDX_MF_OFFSET || idx == `IDX_DEV_ID || idx == `IDX_USER_LO ||
       idx == `IDX_USER_HI || idx == `IDX_STATUS);
   assign chk_mode = link_mode_control_third[`CHK_MSB:`CHK_LSB];
   assign pat_code = link_mode_control_third[`PAT_MSB:`PAT_LSB];

   // read mux: narrow registers sit in the low byte, upper bits read zero
   always @* begin
      case (idx)
         `IDX_MODE_CTL2: next_rdata = link_mode_second;
         `IDX_MODE_CTL3: next_rdata = link_mode_control_third;
         `IDX_MODE_CTL4: next_rdata = link_mode_control_fourth;
         `IDX_MF_OFFSET: next_rdata = multiframe_phase_offset;
         `IDX_DEV_ID: next_rdata = device_identifier;
         `IDX_USER_LO: next_rdata = user_lo;
         `IDX_USER_HI: next_rdata = user_hi;
         `IDX_STATUS: next_rdata = {5'b00000, fifo_empty, fifo_full, single_done};
         default: next_rdata = 8'h00;
      endcase
   end

   // one wait state: pready rises in the second access cycle, so every
   // output of the slave comes from a flop
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= setup;
         pslverr <= setup & ~mapped;
         if (rd_take) begin
            prdata <= {24'h000000, next_rdata};
         end else if (setup) begin
            prdata <= 32'h00000000;
         end
      end
   end

   // writable registers; unmapped or read-only writes are dropped
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link_mode_second <= `RST_REG8;
         link_mode_control_third <= `RST_REG8;
         link_mode_control_fourth <= `RST_REG8;
         multiframe_phase_offset <= `RST_REG8;
         device_identifier <= `RST_REG8;
         user_lo <= `RST_REG8;
         user_hi <= `RST_REG8;
      end else if (wr_take) begin
         case (idx)
            `IDX_MODE_CTL2: link_mode_second <= pwdata[7:0];
            `IDX_MODE_CTL3: link_mode_control_third <= pwdata[7:0];
            `IDX_MODE_CTL4: link_mode_control_fourth <= pwdata[7:0];
            `IDX_MF_OFFSET: multiframe_phase_offset <= pwdata[7:0];
            `IDX_DEV_ID: device_identifier <= pwdata[7:0];
            `IDX_USER_LO: user_lo <= pwdata[7:0];
            `IDX_USER_HI: user_hi <= pwdata[7:0];
            default: user_lo <= user_lo;
         endcase
      end
   end

   // ***********************************
   // configuration checksum
   // ***********************************
   // octet layout: 0 id, 1 bank, 2 lane, 3 lanes/scr, 4 f, 5 k, 6 m,
   // 7 n/cs, 8 n'/subclass, 9 s/version, 10 cf/hd
   always @* begin
      sum_oct = 8'h00;
      for (k = 0; k < `CFG_OCTETS; k = k + 1) begin
         sum_oct = sum_oct + cfg_octets[8*k +: 8]; // see R1
      end
      sum_fld = cfg_octets[7:0] + {4'h0, cfg_octets[11:8]} + {4'h0, cfg_octets[15:12]}
         + {3'b000, cfg_octets[20:16]} + {7'h00, cfg_octets[21]}
         + {7'h00, cfg_octets[22]} + {3'b000, cfg_octets[28:24]}
         + {7'h00, cfg_octets[31]} + cfg_octets[39:32] + {3'b000, cfg_octets[44:40]}
         + cfg_octets[55:48] + {3'b000, cfg_octets[60:56]}
         + {6'h00, cfg_octets[63:62]} + {3'b000, cfg_octets[68:64]}
         + {5'h00, cfg_octets[71:69]} + {3'b000, cfg_octets[76:72]}
         + {5'h00, cfg_octets[79:77]} + {3'b000, cfg_octets[84:80]}
         + {7'h00, cfg_octets[87]}; // see R2
      case (chk_mode)
         `CHK_OCTETS: next_checksum = sum_oct; // see R1
         `CHK_FIELDS: next_checksum = sum_fld; // see R2
         `CHK_ZERO: next_checksum = 8'h00; // see R3
         default: next_checksum = sum_oct;
      endcase
   end

   // registered so the framer sees a stable value, one cycle after a change
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         config_checksum <= 8'h00;
         insert_point <= 2'b00;
      end else begin
         config_checksum <= next_checksum;
         insert_point <= link_mode_control_third[`INS_MSB:`INS_LSB]; // see R4
      end
   end

   // ***********************************
   // sample path
   // ***********************************
   sample_fifo #(
      .WIDTH(`SAMPLE_W),
      .DEPTH(`FIFO_DEPTH),
      .AW(`FIFO_AW)
   ) u_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .in_data(in_data),
      .in_valid(in_valid),
      .in_ready(in_ready),
      .out_data(fifo_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_take),
      .full(fifo_full),
      .empty(fifo_empty)
   );

   assign pat_known = (pat_code == `PAT_CHECKER) || (pat_code == `PAT_TOGGLE) ||
      (pat_code == `PAT_PN23) || (pat_code == `PAT_PN9) || (pat_code == `PAT_PN7) ||
      (pat_code == `PAT_RAMP) || (pat_code == `PAT_USER_REP) ||
      ((pat_code == `PAT_USER_ONE) && !single_done);
   assign load = ~out_valid | out_ready;
   // while a pattern plays the converter samples are discarded so the
   // source is never back-pressured into overflow
   assign fifo_take = use_pattern | load;
   assign adv23 = load && use_pattern && pat_code == `PAT_PN23;
   assign adv9 = load && use_pattern && pat_code == `PAT_PN9;
   assign adv7 = load && use_pattern && pat_code == `PAT_PN7;
   assign user_sent = load && use_pattern && pat_code == `PAT_USER_ONE;
   assign clr_done = wr_take && idx == `IDX_MODE_CTL3;

   pn_source #(.LEN(23), .TAP(18)) u_pn23 (
      .pclk(pclk), .presetn(presetn), .advance(adv23), .word(pn23_word)); // see R7
   pn_source #(.LEN(9), .TAP(5)) u_pn9 (
      .pclk(pclk), .presetn(presetn), .advance(adv9), .word(pn9_word));
   pn_source #(.LEN(7), .TAP(6)) u_pn7 (
      .pclk(pclk), .presetn(presetn), .advance(adv7), .word(pn7_word));

   // pattern selection; unknown codes fall back to live data
   always @* begin
      use_pattern = pat_known; // see R14
      case (pat_code)
         `PAT_CHECKER: next_out = phase ? `CHECKER_B : `CHECKER_A; // see R6
         `PAT_TOGGLE: next_out = phase ? `WORD_ZERO : `WORD_ONES; // see R6
         `PAT_PN23: next_out = pn23_word; // see R7
         `PAT_PN9: next_out = pn9_word;
         `PAT_PN7: next_out = pn7_word;
         `PAT_RAMP: next_out = ramp;
         `PAT_USER_REP: next_out = {user_hi, user_lo}; // see R8
         `PAT_USER_ONE: next_out = {user_hi, user_lo}; // see R9
         default: next_out = fifo_data; // see R5
      endcase
   end

   // output stage; the pn words lag their advance by one word, harmless
   // for a free-running sequence
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_data <= 16'h0000;
         out_valid <= 1'b0;
         phase <= 1'b0;
         ramp <= 16'h0000;
         test_active <= 1'b0;
      end else begin
         test_active <= use_pattern;
         if (load) begin
            if (use_pattern) begin
               out_data <= next_out;
               out_valid <= 1'b1;
               phase <= ~phase;
               if (pat_code == `PAT_RAMP) begin
                  ramp <= ramp + 1'b1;
               end
            end else begin
               out_data <= fifo_data; // see R5
               out_valid <= fifo_valid;
            end
         end
      end
   end

   // single-shot flag: a send in the same cycle as the rearming write wins
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         single_done <= 1'b0;
      end else if (user_sent) begin
         single_done <= 1'b1; // see R9
      end else if (clr_done) begin
         single_done <= 1'b0;
      end
   end

   // ***********************************
   // link layer test characters
   // ***********************************
   assign llt_known = (link_mode_control_fourth[`LLT_MSB:`LLT_LSB] == `LLT_D215) ||
      (link_mode_control_fourth[`LLT_MSB:`LLT_LSB] == `LLT_RPAT) ||
      (link_mode_control_fourth[`LLT_MSB:`LLT_LSB] == `LLT_JSPAT) ||
      (link_mode_control_fourth[`LLT_MSB:`LLT_LSB] == `LLT_JTSPAT);

   // the jitter sequences are given as an octet stream; the framer adds
   // disparity control and, for the scrambled ones, the scrambler
   always @* begin
      case (link_mode_control_fourth[`LLT_MSB:`LLT_LSB])
         `LLT_D215: next_char = `CHAR_D215; // see R11
         `LLT_RPAT: next_char = link_seq ^ `CHAR_D215; // see R12
         `LLT_JSPAT: next_char = link_seq; // see R13
         `LLT_JTSPAT: next_char = ~link_seq; // see R13
         default: next_char = 8'h00; // see R10
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link_test_mode <= `LLT_NORMAL;
         link_char <= 8'h00;
         link_seq <= 8'h00;
      end else begin
         link_test_mode <= llt_known ? link_mode_control_fourth[`LLT_MSB:`LLT_LSB]
            : `LLT_NORMAL; // see R14
         link_char <= next_char;
         link_seq <= llt_known ? (link_seq + 8'h1D) : 8'h00;
      end
   end
endmodule

// File: dv/link_test_ctl_asserts.sv
// concurrent checks on the ports of the link test control block
// assumes apb byte address is four times the register index
`timescale 1ns/1ps
module link_test_ctl_asserts (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [15:0] paddr,
   input wire [31:0] pwdata,
   input wire pready,
   input wire pslverr,
   input wire [15:0] out_data,
   input wire out_valid,
   input wire out_ready,
   input wire [87:0] cfg_octets,
   input wire [7:0] config_checksum,
   input wire [1:0] insert_point,
   input wire test_active,
   input wire [2:0] link_test_mode,
   input wire [7:0] link_char
);
   // ******************
   // shadow of the test control register
   // ******************
   reg [7:0] ctl3;
   reg [7:0] octet_sum;
   integer k;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // write lands at the edge ending the first access cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ctl3 <= 8'h00;
      else if (psel && penable && !pready && pwrite && paddr == 16'h15CC)
         ctl3 <= pwdata[7:0];
   end
   // octet sum, wrapping at 8 bits
   always @* begin
      octet_sum = 8'h00;
      for (k = 0; k < 11; k = k + 1)
         octet_sum = octet_sum + cfg_octets[8*k +: 8];
   end
   a_apb_answer: assert property (psel && penable && !pready |=> pready)
      else $error("apb access not answered");
   a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
   a_ready_pulse: assert property (pready |=> !pready) else $error("ready longer than a cycle");
   a_link_legal: assert property (link_test_mode inside {3'h0, 3'h1, 3'h4, 3'h5, 3'h6})
      else $error("reserved link test code active");
   a_d215_char: assert property (link_test_mode == 3'h1 && $past(link_test_mode) == 3'h1
      && $past(link_test_mode, 2) == 3'h1 |-> link_char == 8'hB5) else $error("wrong idle char");
   a_stall_holds: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("output word dropped under stall");
   a_sum_octets: assert property ($past(presetn) && ctl3[7:6] inside {2'h0, 2'h3}
      && $stable(ctl3) && $stable(cfg_octets) |-> config_checksum == octet_sum)
      else $error("octet checksum wrong");
   a_sum_zero: assert property (ctl3[7:6] == 2'h2 && $past(ctl3[7:6]) == 2'h2
      |-> config_checksum == 8'h00) else $error("checksum not zero");
   a_insert_point: assert property ($stable(ctl3) |-> insert_point == ctl3[5:4])
      else $error("insertion point mismatch");
   a_idle_no_test: assert property (ctl3[3:0] == 4'h0 && $past(ctl3[3:0]) == 4'h0
      |-> !test_active) else $error("test active in normal mode");
   a_pattern_on: assert property (ctl3[3:0] inside {4'h1, 4'h2} && $stable(ctl3)
      |-> test_active) else $error("pattern not active");
endmodule
bind link_test_ctl link_test_ctl_asserts i_link_test_ctl_asserts (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .out_data, .out_valid, .out_ready,
   .cfg_octets, .config_checksum, .insert_point, .test_active, .link_test_mode, .link_char);

// File: dv/link_rx_model.sv
// receiving end of the sample stream: takes words at a chosen pace
// assumes one clock shared with the block; pace 0 prompt, 1 slow, 2 stopped
`timescale 1ns/1ps
module link_rx_model (
   input wire pclk,
   input wire presetn,
   input wire [15:0] out_data,
   input wire out_valid,
   output reg out_ready,
   input wire [1:0] pace,
   output reg rx_take,
   output reg [15:0] rx_word
);
   // ******************
   // pacing and capture
   // ******************
   reg [1:0] phase;
   // slow pace accepts one cycle in four so the sender must hold its word
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase <= 2'h0;
         out_ready <= 1'b0;
         rx_take <= 1'b0;
         rx_word <= 16'h0000;
      end else begin
         phase <= phase + 2'h1;
         out_ready <= pace == 2'h0 || (pace == 2'h1 && phase == 2'h3);
         rx_take <= out_valid && out_ready;
         rx_word <= out_data;
      end
   end
endmodule

// File: dv/tb.sv
// self-checking bench for the link test control block
// assumes the checker is bound in and the receiver model drives out_ready
`timescale 1ns/1ps
module tb;
   reg pclk = 1'b0;
   reg presetn = 1'b0;
   reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, in_valid = 1'b0, capture = 1'b0;
   reg [15:0] paddr = 16'h0000, in_data = 16'h0000, user;
   reg [31:0] pwdata = 32'h0, seed = 32'hE051D33D;
   reg [87:0] cfg_octets = 88'h0;
   reg [1:0] pace = 2'h2;
   wire [31:0] prdata;
   wire [15:0] out_data, rx_word;
   wire [7:0] config_checksum, link_char, link_mode_second, multiframe_phase_offset;
   wire [7:0] device_identifier;
   wire [2:0] link_test_mode;
   wire [1:0] insert_point;
   wire pready, pslverr, in_ready, out_valid, out_ready, test_active, rx_take;
   integer failures = 0, tests_run = 0, i, j, n, ln, tp, ea, eb;
   reg [33:0] apb_q[$];
   reg [15:0] word_q[$], cap[$];
   reg [7:0] sum, code;
   reg bits [0:95];
   reg ok;
   always #2.5 pclk = ~pclk;
   link_test_ctl i_link_test_ctl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .in_data, .in_valid, .in_ready, .out_data, .out_valid,
      .out_ready, .cfg_octets, .config_checksum, .insert_point, .test_active, .link_test_mode,
      .link_char, .link_mode_second, .multiframe_phase_offset, .device_identifier);
   link_rx_model i_link_rx_model (.pclk, .presetn, .out_data, .out_valid, .out_ready, .pace,
      .rx_take, .rx_word);
   // ******************
   // helpers
   // ******************
   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task tally_and_finish;
      if (failures == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task check(input [31:0] got, input [31:0] exp);
      tests_run = tests_run + 1;
      if (got !== exp) begin
         failures = failures + 1;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task tick(input integer c);
      repeat (c) @(posedge pclk);
   endtask
   // the request is held until pready is seen high at a rising edge
   task apb(input w, input [15:0] a, input [31:0] d, input e, input [31:0] x);
      integer c;
      begin
         apb_q.push_back({w, e, x});
         psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         c = 0;
         @(posedge pclk);
         while (pready !== 1'b1 && c < 50) begin
            @(posedge pclk);
            c = c + 1;
         end
         if (c == 50) begin
            check(0, 1);
            tally_and_finish;
         end
         psel <= 1'b0; penable <= 1'b0;
         @(posedge pclk);
      end
   endtask
   task wr(input [15:0] a, input [31:0] d);
      apb(1'b1, a, d, 1'b0, 32'h0);
   endtask
   task rd(input [15:0] a, input [31:0] x);
      apb(1'b0, a, 32'h0, 1'b0, x);
   endtask
   task drain;
      for (n = 0; word_q.size() != 0 && n < 2000; n = n + 1) @(posedge pclk);
      check(word_q.size(), 0);
   endtask
   // ******************
   // result watchers
   // ******************
   // each apb answer retires the oldest noted expectation
   always @(posedge pclk) if (pready === 1'b1) begin
      if (apb_q.size() == 0) check(1, 0);
      else begin
         check(pslverr, apb_q[0][32]);
         if (!apb_q[0][33]) check(prdata, apb_q[0][31:0]);
         void'(apb_q.pop_front());
      end
   end
   // words seen by the receiver are either captured or matched in order
   always @(posedge pclk) if (rx_take === 1'b1) begin
      if (capture) cap.push_back(rx_word);
      else if (word_q.size() == 0) check(rx_word, 32'hDEAD0000);
      else check(rx_word, word_q.pop_front());
   end
   // ******************
   // scenarios
   // ******************
   initial begin
      tick(20);
      presetn <= 1'b1;
      tick(2);
      for (i = 0; i < 5; i = i + 1) begin
         ln = i == 3 ? 16'h15E0 : i == 4 ? 16'h1600 : 16'h15C8 + 4 * i;
         rd(ln[15:0], 32'h0);
         seed = lfsr(seed);
         wr(ln[15:0], i == 1 ? seed & 32'hF0 : seed);
         rd(ln[15:0], i == 1 ? seed & 32'hF0 : seed & 32'hFF);
         if (i != 1 && i != 2) check(i == 0 ? link_mode_second : i == 3 ?
            multiframe_phase_offset : device_identifier, seed[7:0]);
      end
      apb(1'b0, 16'h1000, 32'h0, 1'b1, 32'h0);
      apb(1'b1, 16'h15C9, 32'h5A, 1'b1, 32'h0);
      for (j = 0; j < 4; j = j + 1) begin
         seed = lfsr(seed); cfg_octets[31:0] <= seed;
         seed = lfsr(seed); cfg_octets[63:32] <= seed;
         seed = lfsr(seed); cfg_octets[87:64] <= seed[23:0];
         if (j == 3) cfg_octets <= {88{1'b1}};
         code = {j == 0 ? 2'h0 : j == 1 ? 2'h3 : j == 2 ? 2'h2 : 2'h1, j[1:0], 4'h0};
         wr(16'h15CC, code);
         tick(3);
         sum = 8'h00;
         for (i = 0; i < 11; i = i + 1) sum = sum + cfg_octets[8*i +: 8];
         check(config_checksum, j == 2 ? 8'h00 : j == 3 ? 8'h09 : sum);
         check(insert_point, j);
         check(test_active, 0);
      end
      for (j = 0; j < 8; j = j + 1) begin
         wr(16'h15D0, j);
         tick(3);
         check(link_test_mode, j inside {1, 4, 5, 6} ? j : 0);
         if (j == 1) check(link_char, 8'hB5);
      end
      wr(16'h15CC, 32'h0);
      n = 0;
      seed = lfsr(seed); in_data <= seed[15:0]; in_valid <= 1'b1;
      @(posedge pclk);
      for (i = 0; in_ready === 1'b1 && i < 40; i = i + 1) begin
         word_q.push_back(in_data);
         seed = lfsr(seed); in_data <= seed[15:0];
         @(posedge pclk);
      end
      in_valid <= 1'b0;
      check(i >= 16 && i <= 18, 1);
      rd(16'h1648, 32'h2);
      pace <= 2'h1;
      drain;
      tick(10);
      rd(16'h1648, 32'h4);
      pace <= 2'h0;
      seed = lfsr(seed); user = seed[15:0];
      wr(16'h1640, user[7:0]);
      wr(16'h1644, user[15:8]);
      for (j = 0; j < 7; j = j + 1) begin
         code = j == 0 ? 8'h1 : j == 1 ? 8'h2 : j == 2 ? 8'h8 : j == 3 ? 8'h4 :
            j == 4 ? 8'h6 : j == 5 ? 8'h7 : 8'hE;
         cap.delete();
         capture = 1'b1;
         wr(16'h15CC, code);
         tick(40);
         check(test_active, 1);
         wr(16'h15CC, 32'h0);
         tick(10);
         capture = 1'b0;
         check(cap.size() >= 11, 1);
         if (cap.size() >= 11) begin
            ok = 1'b1;
            for (i = 3; i < 11; i = i + 1) case (code)
               8'h1: ok &= cap[i] == ~cap[i-1] && cap[i] inside {16'hAAAA, 16'h5555};
               8'h2: ok &= cap[i] == ~cap[i-1] && cap[i] inside {16'hFFFF, 16'h0000};
               8'h8: ok &= cap[i] == cap[i-1] + 16'h1;
               8'hE: ok &= cap[i] == user;
               default: ;
            endcase
            if (code inside {8'h4, 8'h6, 8'h7}) begin
               ln = code == 8'h4 ? 23 : code == 8'h6 ? 9 : 7;
               tp = code == 8'h4 ? 18 : code == 8'h6 ? 5 : 6;
               for (i = 0; i < 96; i = i + 1) bits[i] = cap[3 + i / 16][15 - i % 16];
               {ea, eb} = 0;
               for (i = ln; i < 96; i = i + 1) begin
                  ea += bits[i] != (bits[i-tp] ^ bits[i-ln]);
                  eb += bits[i] != (bits[i-ln+tp] ^ bits[i-ln]);
               end
               ok = (ea == 0 || eb == 0) && (cap[3] | cap[4]) != 16'h0;
            end
            check(ok, 1);
         end
      end
      cap.delete();
      capture = 1'b1;
      wr(16'h15CC, 32'hF);
      tick(20);
      capture = 1'b0;
      check(cap.size(), 1);
      if (cap.size() == 1) check(cap[0], user);
      rd(16'h1648, 32'h5);
      seed = lfsr(seed); word_q.push_back(seed[15:0]);
      in_data <= seed[15:0]; in_valid <= 1'b1;
      tick(1);
      in_valid <= 1'b0;
      drain;
      wr(16'h15CC, 32'h0);
      rd(16'h1648, 32'h4);
      tick(10);
      tally_and_finish;
   end
endmodule
